/* File: dv/spsq_bench.sv */
// self-checking bench for the card pin and power sequencer
`timescale 1ns/10ps
`include "spsq_map.svh"
module sd_card_spi_power_pin_sequencer_bench
  import spsq_pkg::*;
();
  localparam int MS = 4;
  logic          clock = 1'b0;
  logic          rst = 1'b1;
  logic [31:0]   haddr = 32'h0000_0000;
  logic [1:0]    htrans = 2'h0;
  logic          hwrite = 1'b0;
  logic [31:0]   hwdata = 32'h0000_0000;
  wire           hready;
  logic [31:0]   hrdata;
  logic          hreadyout;
  logic          hresp;
  logic          want_in = 1'b0;
  logic          yank = 1'b0;
  logic          pwr_high = 1'b1;
  logic          card_present_n;
  logic          data_line;
  spsq_pin_cfg_s data_in_cfg;
  spsq_pin_cfg_s data_out_cfg;
  spsq_pin_cfg_s clock_cfg;
  spsq_pin_cfg_s power_cfg;
  int            error_cnt = 0;
  int            n_checks = 0;
  int            seed = 32'h74d2;
  int            on_ms;
  int            off_ms;
  logic [31:0]   r;

  // clock and single-slave bus ready
  always #20 clock = ~clock;
  assign hready = hreadyout;

  spsq_top #(.MS_CYCLES(MS)) u_dut (
    .clock(clock), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .card_present_n(card_present_n),
    .uart_block_data_in_pin(data_line), .data_in_cfg(data_in_cfg),
    .data_out_cfg(data_out_cfg), .clock_cfg(clock_cfg), .power_cfg(power_cfg));

  spsq_card_model u_card (
    .clock(clock), .rst(rst), .want_in(want_in), .yank(yank), .pwr_high(pwr_high),
    .power_cfg(power_cfg), .data_out_cfg(data_out_cfg),
    .card_present_n(card_present_n), .data_line(data_line));

  // expected settle length and power pin setting
  function automatic int settle(input int ms);
    return ((ms == 0) ? 1 : ms) * MS + 1;
  endfunction
  function automatic logic [5:0] pwr_exp(input logic on, input logic hi);
    return {3'b001, ~(on ^ hi), 2'b00};
  endfunction

  // comparisons
  task automatic fail(input string what);
    error_cnt++;
    $display("ERROR %0t: %s", $time, what);
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp,
                       input logic [31:0] m, input string what);
    n_checks++;
    if ((got & m) !== (exp & m)) fail(what);
  endtask
  task automatic chk6(input spsq_pin_cfg_s got, input logic [5:0] exp,
                      input logic [5:0] m, input string what);
    n_checks++;
    if ((got & m) !== (exp & m)) fail(what);
  endtask
  task automatic chkn(input int got, input int lo, input int hi, input string what);
    n_checks++;
    if (got < lo || got > hi) fail(what);
  endtask

  // one single ahb-lite transfer, read data taken at the data phase end
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    // only the watchdog ends a wait for ready
    do begin
      @(posedge clock);
    end while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clock);
    end while (hready !== 1'b1);
    rd = hrdata;
    chk32({31'h0000_0000, hresp}, 32'h0000_0000, 32'h0000_0001, "slave answered with error");
  endtask

  // poll status until the masked field matches
  task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      bus(1'b0, `SPSQ_OFS_STATUS, 32'h0000_0000, r);
      n++;
    end while ((r & m) !== v && n < 1000);
    if (n >= 1000) fail("status wait timed out");
  endtask

  // insertion walk, one step per edge, then on settle
  task automatic run_insert(input logic hi);
    int n;
    bus(1'b1, `SPSQ_OFS_CMD, 32'h0000_0001, r);
    #1;
    chk6(data_in_cfg, 6'h00, 6'h3f, "data-in pin not plain input");
    chk6(data_out_cfg, 6'h09, 6'h3f, "data-out pin not parked low");
    chk6(clock_cfg, 6'h09, 6'h3f, "clock pin not parked low");
    @(posedge clock);
    #1;
    chk6(power_cfg, pwr_exp(1'b0, hi), 6'h3c, "power pin not off in step two");
    @(posedge clock);
    #1;
    chk6(power_cfg, pwr_exp(1'b1, hi), 6'h3c, "power pin not on in step three");
    @(posedge clock);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (data_out_cfg.port_function_select !== 1'b1 && n < 2000);
    chkn(n, settle(on_ms), settle(on_ms), "on settle length");
    chk6(data_out_cfg, 6'h30, 6'h30, "serial pins not handed over");
    bus(1'b0, `SPSQ_OFS_STATUS, 32'h0000_0000, r);
    chk32(r, 32'h0000_0c20, 32'h0000_0cff, "status not ready with supply");
  endtask

  // power down and off settle, planned or unexpected
  task automatic run_remove(input logic hi, input logic unexp);
    int n;
    realtime t0;
    if (unexp) begin
      yank    <= 1'b1;
      want_in <= 1'b0;
      n = 0;
      do begin
        @(posedge clock);
        #1;
        n++;
      end while (power_cfg.port_output_level !== ~hi && n < 20);
    end else begin
      bus(1'b1, `SPSQ_OFS_CMD, 32'h0000_0002, r);
      #1;
    end
    t0 = $realtime;
    chk6(power_cfg, pwr_exp(1'b0, hi), 6'h3c, "power pin not off on removal");
    chk6(data_out_cfg, 6'h09, 6'h3f, "serial pins not re-parked");
    if (unexp) begin
      bus(1'b0, `SPSQ_OFS_STATUS, 32'h0000_0000, r);
      chk32(r, 32'h0000_1000, 32'h0000_1000, "unexpected flag not set");
      bus(1'b1, `SPSQ_OFS_STATUS, 32'h0000_1000, r);
    end
    wait_st(32'h0000_00ff, 32'h0000_0001);
    n = int'(($realtime - t0) / 40.0);
    chkn(n, settle(off_ms), settle(off_ms) + 6, "off settle length");
    chk32(r, 32'h0000_0001, 32'h0000_18ff, "status not idle and off");
    want_in <= 1'b0;
    yank    <= 1'b0;
    // let the card leave before the polarity or the next insert changes
    repeat (4) @(posedge clock);
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk6(power_cfg, 6'h00, 6'h3f, "power pin driven out of reset");
    chk6(data_in_cfg, 6'h00, 6'h3f, "pin cfg not cleared");
    repeat (3) @(posedge clock);
    bus(1'b0, `SPSQ_OFS_CTRL, 32'h0000_0000, r);
    chk32(r, {28'h000_0000, `SPSQ_CTRL_RST}, 32'hffff_ffff, "control reset value");
    bus(1'b0, `SPSQ_OFS_TIME, 32'h0000_0000, r);
    chk32(r, {`SPSQ_TIME_RST, `SPSQ_TIME_RST}, 32'hffff_ffff, "time reset value");
    bus(1'b0, `SPSQ_OFS_STATUS, 32'h0000_0000, r);
    chk32(r, 32'h0000_0201, 32'h0000_1fff, "status reset value");
    bus(1'b1, 8'h10, $random(seed), r);
    bus(1'b0, 8'h10, 32'h0000_0000, r);
    chk32(r, 32'h0000_0000, 32'hffff_ffff, "unmapped read not zero");
    bus(1'b1, `SPSQ_OFS_CMD, 32'h0000_0003, r);
    bus(1'b0, `SPSQ_OFS_STATUS, 32'h0000_0000, r);
    chk32(r, 32'h0000_0001, 32'h0000_00ff, "sequence left idle without card");
    // planned removals over both polarities, then an unexpected one
    for (int k = 0; k < 4; k++) begin
      on_ms    = (k == 0) ? 0 : ($random(seed) & 3);
      off_ms   = $random(seed) & 3;
      pwr_high <= k[0];
      bus(1'b1, `SPSQ_OFS_TIME, {off_ms[15:0], on_ms[15:0]}, r);
      bus(1'b1, `SPSQ_OFS_CTRL, {28'h000_0000, 2'b10, k[0], 1'b1}, r);
      want_in <= 1'b1;
      wait_st(32'h0000_0100, 32'h0000_0100);
      run_insert(k[0]);
      run_remove(k[0], k == 3);
    end
    // auto insertion on card detect
    bus(1'b1, `SPSQ_OFS_CTRL, 32'h0000_000f, r);
    want_in <= 1'b1;
    wait_st(32'h0000_0400, 32'h0000_0400);
    chk6(power_cfg, pwr_exp(1'b1, 1'b1), 6'h3c, "auto insert not powered");
    run_remove(1'b1, 1'b0);
    // card pulled out while the supply is still settling
    on_ms  = 3;
    off_ms = 0;
    bus(1'b1, `SPSQ_OFS_TIME, 32'h0000_0003, r);
    want_in <= 1'b1;
    wait_st(32'h0000_00ff, 32'h0000_0010);
    run_remove(1'b1, 1'b1);
    tally_and_finish();
  end

  // watchdog against a hung handshake or sequence
  initial begin
    #(40 * 40000);
    error_cnt++;
    tally_and_finish();
  end

  // verdict
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
endmodule

/* File: dv/spsq_card_model.sv */
// card and supply switch model facing the pin sequencer
`timescale 1ns/10ps
module spsq_card_model
  import spsq_pkg::*;
(
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // bench requests
  input  wire logic          want_in,
  input  wire logic          yank,
  input  wire logic          pwr_high,
  // host pins seen by the card
  input  wire spsq_pin_cfg_s power_cfg,
  input  wire spsq_pin_cfg_s data_out_cfg,
  output logic               card_present_n,
  output logic               data_line
);
  logic supply_on;
  logic pat;

  // switch conducts only while the pin is driven at its on level
  assign supply_on = power_cfg.port_direction & (power_cfg.port_output_level == pwr_high);

  // card goes in with serial outputs low, leaves unpowered unless yanked
  always @(posedge clock) begin
    if (rst) begin
      card_present_n <= 1'b1;
      pat            <= 1'b0;
    end else begin
      pat <= ~pat;
      if (want_in && !(data_out_cfg.port_direction && data_out_cfg.port_output_level)) begin
        card_present_n <= 1'b0;
      end else if (!want_in && (!supply_on || yank)) begin
        card_present_n <= 1'b1;
      end
    end
  end

  // board pull-up holds the line high unless a powered card drives it
  assign data_line = (!card_present_n && supply_on) ? pat : 1'b1;
endmodule

/* File: rtl/spsq_map.svh */
// offsets, field positions, reset values and timing counts of the card pin sequencer
`ifndef SPSQ_MAP_SVH
`define SPSQ_MAP_SVH

// clock period and settle time unit
`define SPSQ_CLK_NS        40
`define SPSQ_MS_NS         1000000

// register byte offsets
`define SPSQ_OFS_CTRL      8'h00
`define SPSQ_OFS_CMD       8'h04
`define SPSQ_OFS_TIME      8'h08
`define SPSQ_OFS_STATUS    8'h0c

// control fields
`define SPSQ_CTRL_PWR_EN   0
`define SPSQ_CTRL_PWR_HIGH 1
`define SPSQ_CTRL_AUTO     2
`define SPSQ_CTRL_PERIPH   3
`define SPSQ_CTRL_RST      4'h2

// command fields
`define SPSQ_CMD_INSERT    0
`define SPSQ_CMD_REMOVE    1

// settle time fields and reset value in ms
`define SPSQ_TIME_RST      16'h0064

// status fields
`define SPSQ_ST_PRESENT    8
`define SPSQ_ST_DATA_IN    9
`define SPSQ_ST_READY      10
`define SPSQ_ST_SUPPLY_ON  11
`define SPSQ_ST_UNEXP      12

`endif

/* File: rtl/spsq_ms_timer.sv */
// millisecond settle timer, one done pulse after ms milliseconds (0 counts as 1)
`timescale 1ns/10ps
module spsq_ms_timer
  import spsq_pkg::*;
#(
  parameter int unsigned MS_CYCLES = 25000
)(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // start request and length
  input  wire logic        start,
  input  wire logic [15:0] ms,
  // expiry pulse
  output logic             done
);

  logic [15:0] pre;
  logic [15:0] left;
  logic        run;
  logic [15:0] next_pre;
  logic [15:0] next_left;
  logic        next_run;
  logic        next_done;

  // prescaler to 1 ms ticks, then ms countdown
  always_comb begin
    next_pre  = pre;
    next_left = left;
    next_run  = run;
    next_done = 1'b0;
    if (start) begin
      next_pre  = 16'h0000;
      next_left = ms;
      next_run  = 1'b1;
    end else if (run) begin
      if (pre == 16'(MS_CYCLES - 1)) begin
        next_pre = 16'h0000;
        if (left <= 16'h0001) begin
          next_run  = 1'b0;
          next_done = 1'b1;
        end else begin
          next_left = left - 16'h0001;
        end
      end else begin
        next_pre = pre + 16'h0001;
      end
    end
  end

  // register the timer
  always_ff @(posedge clock) begin
    if (rst) begin
      pre  <= 16'h0000;
      left <= 16'h0000;
      run  <= 1'b0;
      done <= 1'b0;
    end else begin
      pre  <= next_pre;
      left <= next_left;
      run  <= next_run;
      done <= next_done;
    end
  end

endmodule

/* File: rtl/spsq_pkg.sv */
// types shared by the card pin sequencer
package spsq_pkg;

  // sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE     = 8'h01,
    ST_PARK     = 8'h02,
    ST_PWR_OFF  = 8'h04,
    ST_PWR_ON   = 8'h08,
    ST_SET_ON   = 8'h10,
    ST_READY    = 8'h20,
    ST_PWR_DOWN = 8'h40,
    ST_SET_OFF  = 8'h80
  } spsq_state_e;

  // configuration of one host pin
  typedef struct packed {
    logic port_function_select; // 1: peripheral, 0: general port
    logic pin_function_mux;     // 1: peripheral routed, 0: general i/o
    logic port_direction;       // 1: output
    logic port_output_level;
    logic port_pullup_control;  // 1: internal pull-up on
    logic port_drive_strength;  // 1: high drive
  } spsq_pin_cfg_s;

  // captured ahb address phase
  typedef struct packed {
    logic       en;
    logic       write;
    logic [7:0] addr;
  } spsq_req_s;

endpackage

/* File: rtl/spsq_sync.sv */
// two-flop synchroniser for the card detect and data-in pins
`timescale 1ns/10ps
module spsq_sync
  import spsq_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // pins in, synchronised levels out
  input  wire logic [1:0] pin_in,
  output logic      [1:0] pin_sync
);

  logic [1:0] stage1;
  logic [1:0] next_stage1;
  logic [1:0] next_pin_sync;

  // next values of both stages
  always_comb begin
    next_stage1   = pin_in;
    next_pin_sync = stage1;
  end

  // register the stages
  always_ff @(posedge clock) begin
    if (rst) begin
      stage1   <= 2'h3;
      pin_sync <= 2'h3;
    end else begin
      stage1   <= next_stage1;
      pin_sync <= next_pin_sync;
    end
  end

endmodule

/* File: rtl/spsq_top.sv */
// card pin and power sequencer with ahb-lite register slave
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "spsq_map.svh"
module spsq_top
  import spsq_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `SPSQ_MS_NS / `SPSQ_CLK_NS
)(
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // ahb-lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic [31:0]        hrdata,
  output logic               hreadyout,
  output logic               hresp,
  // card side pins
  input  wire logic          card_present_n,
  input  wire logic          uart_block_data_in_pin,
  // pin configurations
  output spsq_pin_cfg_s      data_in_cfg,
  output spsq_pin_cfg_s      data_out_cfg,
  output spsq_pin_cfg_s      clock_cfg,
  output spsq_pin_cfg_s      power_cfg
);

  // pin setting helpers
  function automatic spsq_pin_cfg_s pin_input();
    pin_input = '{default: 1'b0};
  endfunction

  function automatic spsq_pin_cfg_s pin_park_out();
    pin_park_out                      = '{default: 1'b0};
    pin_park_out.port_direction       = 1'b1;
    pin_park_out.port_drive_strength  = 1'b1;
  endfunction

  function automatic spsq_pin_cfg_s pin_periph(input spsq_pin_cfg_s base);
    pin_periph                       = base;
    pin_periph.port_function_select  = 1'b1;
    pin_periph.pin_function_mux      = 1'b1;
  endfunction

  spsq_state_e   state;
  spsq_state_e   next_state;
  spsq_req_s     req;
  spsq_req_s     next_req;
  logic [31:0]   next_hrdata;
  logic [3:0]    ctrl;
  logic [3:0]    next_ctrl;
  logic [15:0]   on_ms;
  logic [15:0]   off_ms;
  logic [15:0]   next_on_ms;
  logic [15:0]   next_off_ms;
  logic          unexp;
  logic          next_unexp;
  logic          present_q;
  logic          next_present_q;
  spsq_pin_cfg_s next_data_in_cfg;
  spsq_pin_cfg_s next_data_out_cfg;
  spsq_pin_cfg_s next_clock_cfg;
  spsq_pin_cfg_s next_power_cfg;
  logic [1:0]    pin_sync;
  logic          present;
  logic          data_in_lvl;
  logic          wr_en;
  logic          cmd_insert;
  logic          cmd_remove;
  logic          insert_req;
  logic          lost;
  logic          timer_start;
  logic [15:0]   timer_ms;
  logic          timer_done;
  logic          off_level;

  // pins from outside the clock domain
  spsq_sync u_sync (
    .clock    (clock),
    .rst      (rst),
    .pin_in   ({card_present_n, uart_block_data_in_pin}),
    .pin_sync (pin_sync)
  );

  assign present     = ~pin_sync[1];
  assign data_in_lvl = pin_sync[0];

  // settle timer, started on leaving a power step
  assign timer_start = (state == ST_PWR_ON) || (state == ST_PWR_DOWN);
  assign timer_ms    = (state == ST_PWR_ON) ? on_ms : off_ms;

  spsq_ms_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .clock (clock),
    .rst   (rst),
    .start (timer_start),
    .ms    (timer_ms),
    .done  (timer_done)
  );

  // bus slave answers with no wait state
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // write data phase decode
  assign wr_en      = req.en && req.write;
  assign cmd_insert = wr_en && (req.addr == `SPSQ_OFS_CMD) && hwdata[`SPSQ_CMD_INSERT];
  assign cmd_remove = wr_en && (req.addr == `SPSQ_OFS_CMD) && hwdata[`SPSQ_CMD_REMOVE];

  // sequencer events
  assign insert_req = cmd_insert || (ctrl[`SPSQ_CTRL_AUTO] && present && !present_q);
  assign lost       = !present;
  assign off_level  = ~ctrl[`SPSQ_CTRL_PWR_HIGH];

  // address phase capture and read data
  always_comb begin
    next_req    = req;
    next_hrdata = hrdata;
    if (hready) begin
      next_req.en    = hsel && htrans[1];
      next_req.write = hwrite;
      next_req.addr  = {haddr[7:2], 2'b00};
      if (hsel && htrans[1] && !hwrite) begin
        unique case ({haddr[7:2], 2'b00})
          `SPSQ_OFS_CTRL:   next_hrdata = {28'h000_0000, ctrl};
          `SPSQ_OFS_TIME:   next_hrdata = {off_ms, on_ms};
          `SPSQ_OFS_STATUS: begin
            next_hrdata                     = {24'h00_0000, state};
            next_hrdata[`SPSQ_ST_PRESENT]   = present;
            next_hrdata[`SPSQ_ST_DATA_IN]   = data_in_lvl;
            next_hrdata[`SPSQ_ST_READY]     = (state == ST_READY);
            next_hrdata[`SPSQ_ST_SUPPLY_ON] = power_cfg.port_direction &&
                                              (power_cfg.port_output_level != off_level);
            next_hrdata[`SPSQ_ST_UNEXP]     = unexp;
          end
          default:          next_hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // software registers
  always_comb begin
    next_ctrl      = ctrl;
    next_on_ms     = on_ms;
    next_off_ms    = off_ms;
    next_unexp     = unexp;
    next_present_q = present;
    if (wr_en && (req.addr == `SPSQ_OFS_CTRL)) begin
      next_ctrl = hwdata[3:0];
    end
    if (wr_en && (req.addr == `SPSQ_OFS_TIME)) begin
      next_on_ms  = hwdata[15:0];
      next_off_ms = hwdata[31:16];
    end
    if (wr_en && (req.addr == `SPSQ_OFS_STATUS) && hwdata[`SPSQ_ST_UNEXP]) begin
      next_unexp = 1'b0;
    end
    // set beats clear
    if (lost && ((state == ST_SET_ON) || (state == ST_READY))) begin
      next_unexp = 1'b1;
    end
  end

  // sequencer state
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:     if (insert_req && present) next_state = ST_PARK;
      ST_PARK:     next_state = ST_PWR_OFF;
      ST_PWR_OFF:  next_state = ST_PWR_ON;
      ST_PWR_ON:   next_state = ST_SET_ON;
      ST_SET_ON: begin
        if (lost) begin
          next_state = ST_PWR_DOWN;
        end else if (timer_done) begin
          next_state = ST_READY;
        end
      end
      ST_READY:    if (lost || cmd_remove) next_state = ST_PWR_DOWN;
      ST_PWR_DOWN: next_state = ST_SET_OFF;
      ST_SET_OFF:  if (timer_done) next_state = ST_IDLE;
      default:     next_state = ST_IDLE;
    endcase
  end

  // pin settings follow the state being entered
  always_comb begin
    next_data_in_cfg  = data_in_cfg;
    next_data_out_cfg = data_out_cfg;
    next_clock_cfg    = clock_cfg;
    next_power_cfg    = power_cfg;
    if ((next_state == ST_PARK) || (next_state == ST_PWR_DOWN)) begin
      next_data_in_cfg  = pin_input();
      next_data_out_cfg = pin_park_out();
      next_clock_cfg    = pin_park_out();
    end
    if ((next_state == ST_READY) && ctrl[`SPSQ_CTRL_PERIPH]) begin
      next_data_in_cfg  = pin_periph(pin_input());
      next_data_out_cfg = pin_periph(pin_park_out());
      next_clock_cfg    = pin_periph(pin_park_out());
    end
    if (next_state == ST_PWR_OFF) begin
      next_power_cfg                   = pin_input();
      next_power_cfg.port_direction    = ctrl[`SPSQ_CTRL_PWR_EN];
      next_power_cfg.port_output_level = off_level;
    end
    if (next_state == ST_PWR_ON) begin
      next_power_cfg.port_output_level = ~off_level;
    end
    if (next_state == ST_PWR_DOWN) begin
      next_power_cfg.port_output_level = off_level;
    end
  end

  // register all state
  always_ff @(posedge clock) begin
    if (rst) begin
      state        <= ST_IDLE;
      req          <= '{default: 1'b0};
      hrdata       <= 32'h0000_0000;
      ctrl         <= `SPSQ_CTRL_RST;
      on_ms        <= `SPSQ_TIME_RST;
      off_ms       <= `SPSQ_TIME_RST;
      unexp        <= 1'b0;
      present_q    <= 1'b0;
      data_in_cfg  <= '{default: 1'b0};
      data_out_cfg <= '{default: 1'b0};
      clock_cfg    <= '{default: 1'b0};
      power_cfg    <= '{default: 1'b0};
    end else begin
      state        <= next_state;
      req          <= next_req;
      hrdata       <= next_hrdata;
      ctrl         <= next_ctrl;
      on_ms        <= next_on_ms;
      off_ms       <= next_off_ms;
      unexp        <= next_unexp;
      present_q    <= next_present_q;
      data_in_cfg  <= next_data_in_cfg;
      data_out_cfg <= next_data_out_cfg;
      clock_cfg    <= next_clock_cfg;
      power_cfg    <= next_power_cfg;
    end
  end

  // cycles spent settling, read only by the checks below
  logic [31:0] settle_cnt;
  always_ff @(posedge clock) begin
    if (rst || !((state == ST_SET_ON) || (state == ST_SET_OFF))) begin
      settle_cnt <= 32'h0000_0000;
    end else begin
      settle_cnt <= settle_cnt + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence insert_steps_s;
    state == ST_PARK ##1 state == ST_PWR_OFF ##1 state == ST_PWR_ON ##1 state == ST_SET_ON;
  endsequence

  sequence down_steps_s;
    state == ST_PWR_DOWN ##1 state == ST_SET_OFF;
  endsequence

  step_order_a: assert property (state == ST_PARK |-> insert_steps_s)
    else $error("insertion steps out of order");

  data_in_park_a: assert property (state == ST_PARK |->
      data_in_cfg == pin_input())
    else $error("data-in pin not a plain input");

  out_park_a: assert property (state == ST_PARK |->
      data_out_cfg == pin_park_out() && clock_cfg == pin_park_out())
    else $error("serial outputs not parked low");

  power_off_step_a: assert property (state == ST_PWR_OFF |->
      power_cfg.port_output_level == off_level &&
      power_cfg.port_direction == ctrl[`SPSQ_CTRL_PWR_EN])
    else $error("power pin not at off level in step two");

  power_on_step_a: assert property (state == ST_PWR_OFF ##1 state == ST_PWR_ON |->
      (power_cfg.port_output_level == ~off_level) [*2] ##1
      (power_cfg.port_output_level == ~off_level || state == ST_PWR_DOWN))
    else $error("power pin not at on level");

  removal_off_a: assert property ((state == ST_READY && lost) |=>
      down_steps_s and power_cfg.port_output_level == off_level)
    else $error("removal did not switch power off");

  on_settle_a: assert property ((state == ST_SET_ON && next_state == ST_READY) |->
      settle_cnt >= ((on_ms == 16'h0000) ? 32'd1 : {16'h0000, on_ms}) * MS_CYCLES)
    else $error("ready before supply settled");

  off_settle_a: assert property ((state == ST_SET_OFF && next_state == ST_IDLE) |->
      settle_cnt >= ((off_ms == 16'h0000) ? 32'd1 : {16'h0000, off_ms}) * MS_CYCLES)
    else $error("idle before supply settled off");

  unexp_flag_a: assert property ((state == ST_SET_ON && lost) |=>
      unexp && state == ST_PWR_DOWN)
    else $error("unexpected removal not flagged");

  pullup_off_a: assert property (state == ST_SET_ON |->
      !data_in_cfg.port_pullup_control && !data_out_cfg.port_pullup_control &&
      !clock_cfg.port_pullup_control)
    else $error("internal pull-up on a serial pin");

endmodule
